// File: src/osec_ctrl.sv
// Purpose: One-second timer, marker pin and device-wide reset and float control
// Assumes: Transmit input clock and marker input are asynchronous and pass the synchroniser
// Notes:   Counter latch strobe goes to the framer counters; pins_enable gates all other pads
//
// Contract
// R1: While general reset is low, all counters and registers return to defaults.
// R2: Outside party keeps transmit, line and dejittered clocks running during reset.
// R3: Float control high puts every output and two-way pin in high impedance.
// R4: Float control low lets outputs and two-way pins drive normally.
// R5: The one-second interval start is the instant event counters latch.
// R6: As input, the marker pin rising edge realigns the internal one-second timer.
// R7: As output, the marker pin rises at each one-second interval start.
// R8: Output timing counts only the first framer's transmit input clock.
// R9: Each driven marker pulse stays high sixteen source clocks, then falls.
// R10: Transmit clock is 44.736 MHz in DS3, 34.368 MHz in E3.
// R11: A setting picks marker direction; pin stays floating after reset until output.

`timescale 1ns/1ps
`default_nettype none

module osec_ctrl
#(
   parameter int unsigned DS3_TICKS = osec_pkg::DS3_TX_HZ,
   parameter int unsigned E3_TICKS  = osec_pkg::E3_TX_HZ
)
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // Device pins
   input  wire logic          general_reset_n,
   input  wire logic          output_float_control,
   input  wire logic          first_framer_tx_clock,
   input  wire logic          second_mark_in,
   output osec_pkg::osec_pad_t second_mark,
   // Configuration
   input  wire logic          e3_mode,
   input  wire logic          second_mark_as_output,
   // To the rest of the device
   output logic               device_reset,
   output logic               pins_enable,
   output logic               counter_latch
);

   logic                         nreset_q;
   logic                         tx_tick;
   logic                         mark_rise;
   logic                         dir_out;
   logic [osec_pkg::TIMER_W-1:0] timer;
   logic [osec_pkg::TIMER_W-1:0] limit;
   logic                         wrap;
   logic                         interval_start;
   logic [4:0]                   pulse_left;
   logic                         mark_level;
   logic [4:0]                   hi_ticks;

   // Pin synchronisers
   osec_sync #(.INIT(1'b1)) u_nreset_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     (general_reset_n),
      .q     (nreset_q),
      .rise  ()
   );

   osec_sync #(.INIT(1'b0)) u_txclk_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     (first_framer_tx_clock),
      .q     (),
      .rise  (tx_tick)
   );

   osec_sync #(.INIT(1'b0)) u_mark_sync
   (
      .clock (clock),
      .rst   (rst),
      .d     (second_mark_in),
      .q     (),
      .rise  (mark_rise)
   );

   // Device-wide reset level from either source
   always_ff @(posedge clock)
   begin
      device_reset <= rst || !nreset_q;   // [R1]
   end

   // Direction setting, floating until configured as output
   always_ff @(posedge clock)
   begin
      if (device_reset)
         dir_out <= 1'b0;   // [R11]
      else
         dir_out <= second_mark_as_output;   // [R11]
   end

   // Terminal count per line mode
   assign limit = e3_mode ? osec_pkg::TIMER_W'(E3_TICKS - 1) : osec_pkg::TIMER_W'(DS3_TICKS - 1);
   assign wrap  = tx_tick && (timer >= limit);   // A mode change to a shorter second still wraps

   // Interval start: own timer as output, pin edge as input
   assign interval_start = dir_out ? wrap : mark_rise;   // [R5] [R6] [R7]

   // One-second timer counted on first framer transmit clock edges
   always_ff @(posedge clock)
   begin
      if (device_reset)
         timer <= osec_pkg::TIMER_RESET;   // [R1]
      else if (!dir_out && mark_rise)
         timer <= osec_pkg::TIMER_RESET;   // [R6]
      else if (wrap)
         timer <= osec_pkg::TIMER_RESET;
      else if (tx_tick)
         timer <= timer + 1'b1;   // [R8]
   end

   // Marker pulse, sixteen transmit clock edges long
   always_ff @(posedge clock)
   begin
      if (device_reset)
      begin
         pulse_left <= osec_pkg::PULSE_RESET;   // [R1]
         mark_level <= 1'b0;
      end
      else if (dir_out && interval_start)
      begin
         pulse_left <= osec_pkg::MARK_PULSE_TICKS;   // [R9]
         mark_level <= 1'b1;   // [R7]
      end
      else if (tx_tick && (pulse_left != 5'h00))
      begin
         pulse_left <= pulse_left - 1'b1;
         if (pulse_left == 5'h01)
            mark_level <= 1'b0;   // [R9]
      end
   end

   // Latch strobe to the event counters
   always_ff @(posedge clock)
   begin
      if (device_reset)
         counter_latch <= 1'b0;
      else
         counter_latch <= interval_start;   // [R5]
   end

   // Pad control; float acts at once, independent of internal state
   assign pins_enable     = !output_float_control;   // [R3] [R4]
   assign second_mark.out = mark_level;
   assign second_mark.oe  = dir_out && !device_reset && !output_float_control;   // [R3] [R4] [R11]

   // Helper: transmit edges counted while the marker is high
   always_ff @(posedge clock)
   begin
      if (device_reset || interval_start)
         hi_ticks <= 5'h00;
      else if (tx_tick && mark_level)
         hi_ticks <= hi_ticks + 1'b1;
   end

   // Checks on the block's own state, all on the one system clock
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence start_seq;
      dir_out && interval_start && !device_reset;
   endsequence

   sequence realign_seq;
      !dir_out && mark_rise && !device_reset;
   endsequence

   sequence last_tick_seq;
      mark_level && tx_tick && (pulse_left == 5'h01) && !interval_start && !device_reset;
   endsequence

   reset_clears_a: assert property (device_reset |=> (timer == 26'h0000000) && (pulse_left == 5'h00)) // [R1]
      else $error("Timer or pulse not cleared by reset");

   float_hiz_a: assert property (output_float_control |-> !second_mark.oe) // [R3]
      else $error("Marker pin driven while float control high");

   float_drive_a: assert property (!output_float_control && dir_out && !device_reset |-> second_mark.oe) // [R4]
      else $error("Marker pin not driven while enabled");

   latch_strobe_a: assert property (interval_start && !device_reset |=> counter_latch) // [R5]
      else $error("Counters not latched at interval start");

   pin_realign_a: assert property (realign_seq |=> (timer == 26'h0000000)) // [R6]
      else $error("Timer not realigned to marker edge");

   mark_rise_a: assert property (start_seq |=> $rose(mark_level) ##0 (pulse_left == 5'h10)) // [R7]
      else $error("Marker did not rise at interval start");

   tick_source_a: assert property (!tx_tick && !mark_rise && !device_reset |=> $stable(timer)) // [R8]
      else $error("Timer moved without a transmit clock edge");

   pulse_length_a: assert property ($fell(mark_level) && !device_reset |-> (hi_ticks == 5'h10)) // [R9]
      else $error("Marker pulse length not sixteen clocks");

   idle_float_a: assert property (!dir_out |-> !second_mark.oe) // [R11]
      else $error("Marker pin driven while set as input");

   latch_pulse_a: assert property (counter_latch |=> !counter_latch) // [R5]
      else $error("Counter latch strobe longer than one cycle");

   pulse_end_a: assert property (last_tick_seq |=> !mark_level && (pulse_left == 5'h00)) // [R9]
      else $error("Marker did not fall at its last tick");

   pulse_live_a: assert property (mark_level && !device_reset |-> (pulse_left != 5'h00)) // [R9]
      else $error("Marker high with no ticks left");

   oe_reset_a: assert property (device_reset |-> !second_mark.oe) // [R11]
      else $error("Marker pin driven during reset");

   dir_reset_a: assert property (device_reset |=> !dir_out) // [R11]
      else $error("Marker direction not cleared by reset");

endmodule // osec_ctrl

`default_nettype wire

// File: src/osec_pkg.sv
// Purpose: Shared constants and carrier types for the one-second timer and global control block
// Assumes: Transmit input clock of the first framer is sampled as an ordinary input on the system clock
// Notes:   Timer and pulse counts and their reset values used by the block live here

package osec_pkg;

   // Transmit input clock rates; one second is this many clock edges
   localparam int unsigned DS3_TX_HZ = 44736000;
   localparam int unsigned E3_TX_HZ  = 34368000;

   // Width of the one-second edge counter
   localparam int unsigned TIMER_W = 26;

   // Length of the marker pulse in transmit clock edges
   localparam logic [4:0] MARK_PULSE_TICKS = 5'h10;

   // Reset values
   localparam logic [TIMER_W-1:0] TIMER_RESET = 26'h0000000;
   localparam logic [4:0]         PULSE_RESET = 5'h00;

   // One two-way pin seen from the core side
   typedef struct packed
   {
      logic out;   // Level driven when enabled
      logic oe;    // High while the device drives the pin
   } osec_pad_t;

endpackage

// File: src/osec_sync.sv
// Purpose: Three-stage synchroniser for an input from outside the clock domain
// Assumes: Input may change at any time relative to clock
// Notes:   Output level moves only when stages two and three agree; rise is a one-cycle pulse

`timescale 1ns/1ps
`default_nettype none

module osec_sync
#(
   parameter logic INIT = 1'b0
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Raw input
   input  wire logic d,
   // Filtered level and its rising edge
   output logic      q,
   output logic      rise
);

   logic s1;
   logic s2;
   logic s3;

   // Shift chain; first stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end
      else
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a change once the later stages agree
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         q    <= INIT;
         rise <= 1'b0;
      end
      else
      begin
         rise <= (s2 == s3) && s3 && !q;
         if (s2 == s3)
            q <= s3;
      end
   end

endmodule // osec_sync

`default_nettype wire

// File: dv/osec_timing_model.sv
// Purpose: Far-side timing logic: first framer tx clock and marker pin
// Assumes: Far side sets the marker pin level through mark_drive while the device releases it
// Notes:   Tx clock is scaled; its edges never meet a system clock edge
`timescale 1ns/1ps
`default_nettype none
module osec_timing_model
(
   // Device side of the marker pad and the far-side drive level
   input  wire osec_pkg::osec_pad_t pad,
   input  wire logic                mark_drive,
   // Pins
   output logic                     tx_clock,
   output logic                     mark_wire
);
   // Free-running tx clock, kept alive through reset too
   initial
   begin
      tx_clock = 1'b0;
      #5;
      forever #70 tx_clock = ~tx_clock;
   end

   // Pin level; released pin follows the far-side mark_drive
   assign mark_wire = pad.oe ? pad.out : mark_drive;
endmodule // osec_timing_model
`default_nettype wire

// File: dv/test_one_second_timer_and_global_control.sv
// Purpose: Self-checking bench for the one-second timer block
// Assumes: Scaled second lengths keep the run short
// Notes:   Inputs change 1 ns after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module test_one_second_timer_and_global_control;
   localparam int DS3_T = 24;
   localparam int E3_T  = 18;
   logic clock, rst, general_reset_n, output_float_control;
   logic e3_mode, second_mark_as_output, mark_drive;
   logic tx_clock, mark_wire, device_reset, pins_enable, counter_latch;
   osec_pkg::osec_pad_t second_mark;
   int err_total, cmp_count;

   osec_ctrl #(.DS3_TICKS(DS3_T), .E3_TICKS(E3_T)) u_osec_ctrl
      (.clock(clock), .rst(rst), .general_reset_n(general_reset_n),
       .output_float_control(output_float_control),
       .first_framer_tx_clock(tx_clock), .second_mark_in(mark_wire),
       .second_mark(second_mark), .e3_mode(e3_mode),
       .second_mark_as_output(second_mark_as_output),
       .device_reset(device_reset), .pins_enable(pins_enable),
       .counter_latch(counter_latch));
   osec_timing_model u_osec_timing_model
      (.pad(second_mark), .mark_drive(mark_drive), .tx_clock(tx_clock), .mark_wire(mark_wire));

   // System clock
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic step();
      @(posedge clock);
      #1;
   endtask

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", n, e, s);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Wait until the marker level is v, counting tx rises; lat is the latch seen as v is reached
   task automatic wait_out(input logic v, inout int cnt, output logic lat);
      logic p;
      p = tx_clock;
      for (int n = 0; n < 2000 && second_mark.out !== v; n++)
      begin
         step();
         lat = counter_latch;
         cnt += int'(tx_clock & !p);
         p = tx_clock;
      end
   endtask

   // One full interval: pulse length, latch timing and period in tx rises
   task automatic measure(input int exp);
      int c;
      int h;
      logic l;
      c = 0;
      h = 0;
      wait_out(1'b0, c, l);
      wait_out(1'b1, c, l);
      check("latch_out", l, 1);
      wait_out(1'b0, h, l);
      check("pulse_len", h, 16);
      c = h;
      wait_out(1'b1, c, l);
      check("period", c, exp);
   endtask

   // Input mode: pin edge latches counters and realigns the timer
   task automatic t_in();
      int c;
      logic l;
      check("oe_idle", second_mark.oe, 0);
      mark_drive = 1'b1;
      for (int n = 0; n < 12 && counter_latch !== 1'b1; n++)
         step();
      check("latch_in", counter_latch, 1);
      check("oe_in", second_mark.oe, 0);
      mark_drive = 1'b0;
      second_mark_as_output = 1'b1;
      c = 0;
      wait_out(1'b0, c, l);
      wait_out(1'b1, c, l);
      check("realign", c >= E3_T - 1 && c <= E3_T + 1, 1);
   endtask

   // Float control overrides and then releases the pins
   task automatic t_float();
      output_float_control = 1'b1;
      #1;
      check("oe_float", second_mark.oe, 0);
      check("pins_float", pins_enable, 0);
      step();
      output_float_control = 1'b0;
      #1;
      check("oe_drive", second_mark.oe, 1);
      check("pins_drive", pins_enable, 1);
      step();
   endtask

   // General reset mid-run clears state, then marking resumes
   task automatic t_greset();
      general_reset_n = 1'b0;
      repeat (6) step();
      check("dev_rst", device_reset, 1);
      check("oe_rst", second_mark.oe, 0);
      check("out_rst", second_mark.out, 0);
      general_reset_n = 1'b1;
      measure(DS3_T);
   endtask

   // Main sequence
   initial
   begin
      err_total = 0;
      cmp_count = 0;
      rst = 1'b1;
      general_reset_n = 1'b1;
      output_float_control = 1'b0;
      e3_mode = 1'b1;
      second_mark_as_output = 1'b0;
      mark_drive = 1'b0;
      repeat (5) step();
      rst = 1'b0;
      repeat (6) step();
      t_in();
      measure(E3_T);
      e3_mode = 1'b0;
      measure(DS3_T);
      t_float();
      t_greset();
      conclude();
   end

   // Watchdog
   initial
   begin
      #200us;
      err_total++;
      conclude();
   end
endmodule // test_one_second_timer_and_global_control
`default_nettype wire
